// [src/clock_gen_params.svh]
// Constants of the clock source sequencer and the prescaler.
// Assumes clk is the selected system clock, running at the rate named below.
// Operation
// - Peripheral clock is the selected system clock divided in a prescaler.
// - CPU clock divides the peripheral clock further, never the system clock.
// - Peripheral divider codes 00/01/10 give /1, /2, /4; software never writes 11.
// - System clock source is taken from the configuration value read after reset.
// - Fast internal oscillator source starts the CPU with no settling wait.
// - Fast internal oscillator source frees both oscillator pins as port pins.
// - Crystal source dedicates both oscillator pins to the resonator.
// - External clock enters on the input pin; output pin becomes a port pin.
// - After power-on, stay stopped about 277 us, then read configuration, select clock.
// - Crystal start brings up the fast internal clock before reading configuration.
// - Crystal clock reaches the CPU only after a configuration-chosen settling wait.
// - Settling on stop-mode exit uses the software selection, not the configuration.
// - Slow internal oscillator always starts when reset is released.
// - If allowed, the software stop bit starts or stops the slow oscillator.
// - If stopping is forbidden, slow oscillator runs and feeds the watchdog.
// - Stop bit gates watchdog and timer per run/standby table; locked watchdog always runs.
// - Slow oscillator runs independently of the CPU clock.
// - Reset loads both CPU and peripheral divider registers with 02H.
// - CPU clock is the system clock /1, /2, /4, /8 or /16 only.
// - Slow oscillator mode register resets to 00H; bit 0 set stops it.
// - Wake settling codes 00..11 give 2^10, 2^12, 2^15, 2^17 system clocks.
`ifndef CLOCK_GEN_PARAMS_SVH
`define CLOCK_GEN_PARAMS_SVH

// Clock rate and power-on hold
`define CG_CLK_KHZ            40000
`define CG_OP_STOP_MIN_US     277
`define CG_OP_STOP_CYCLES     ((`CG_OP_STOP_MIN_US * `CG_CLK_KHZ + 999) / 1000)
`define CG_HS_START_CYCLES    16

// Settling waits as powers of two of system clock cycles
`define CG_SETTLE_LOG2_0      10
`define CG_SETTLE_LOG2_1      12
`define CG_SETTLE_LOG2_2      15
`define CG_SETTLE_LOG2_3      17
`define CG_CNT_W              18

// Register reset values and writable masks
`define CG_RST_CPU_DIV        8'h02
`define CG_RST_PER_DIV        8'h02
`define CG_RST_SLOW_MODE      8'h00
`define CG_RST_SETTLE         8'h00
`define CG_MASK_CPU_DIV       8'h02
`define CG_MASK_PER_DIV       8'h03
`define CG_MASK_SLOW_MODE     8'h01
`define CG_MASK_SETTLE        8'h03

// Field positions
`define CG_CPU_DIV_BIT        1
`define CG_PER_DIV_HI         1
`define CG_PER_DIV_LO         0
`define CG_SLOW_STOP_BIT      0
`define CG_SETTLE_HI          1
`define CG_SETTLE_LO          0

// Divider stage ratio codes
`define CG_RATIO_DIV1         2'h0
`define CG_RATIO_DIV2         2'h1
`define CG_RATIO_DIV4         2'h2
`define CG_RATIO_BAD          2'h3

// Configuration source codes
`define CG_OPT_SRC_HS         2'h0
`define CG_OPT_SRC_XTAL       2'h1
`define CG_OPT_SRC_EXT        2'h2

`endif

// [src/clock_gen_pkg.sv]
// Types shared by the clock source sequencer and its divider stages.
// Assumes the constants header is compiled alongside.
package clock_gen_pkg;

	typedef enum logic [1:0] {SRC_HS_INT, SRC_XTAL, SRC_EXT} clk_src_type;

	typedef enum {ST_POR_WAIT, ST_HS_START, ST_READ_OPT, ST_XTAL_SETTLE,
		ST_RUN, ST_STOP, ST_WAKE_SETTLE} seq_state_type;

endpackage

// [src/div_link_if.sv]
// Link between the sequencer and one divider stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface div_link_if;
	logic       run;
	logic       in_tick;
	logic [1:0] code;
	logic       out_tick;
	logic       out_clk;

	modport stage (input run, input in_tick, input code, output out_tick, output out_clk);
	modport user  (output run, output in_tick, output code, input out_tick, input out_clk);
endinterface

`default_nettype wire

// [src/clock_divider_stage.sv]
// One divide-by-1/2/4 stage counting input ticks.
// Assumes in_tick is a one-cycle enable on clk and code is a ratio code.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_params.svh"

module clock_divider_stage
	import clock_gen_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	div_link_if.stage lnk
);

	logic [1:0] cnt_r, cnt_nxt;
	logic [1:0] code_r, code_nxt;
	logic       tick_r, tick_nxt;
	logic       lvl_r, lvl_nxt;
	logic [1:0] last;
	logic [1:0] safe_code;
	logic [1:0] half;

	////////////////////////////////////////////////////////////////////////
	// Next count, ratio and phase
	always_comb
	begin
		// Illegal code falls back to the slowest ratio, never a short phase
		safe_code = (lnk.code == `CG_RATIO_BAD) ? `CG_RATIO_DIV4 : lnk.code;
		last = 2'h0;
		cnt_nxt = cnt_r;
		code_nxt = code_r;
		tick_nxt = 1'b0;
		if (code_r == `CG_RATIO_DIV2)
			last = 2'h1;
		else if (code_r == `CG_RATIO_DIV4)
			last = 2'h3;
		if (!lnk.run)
		begin
			cnt_nxt = 2'h0;
			code_nxt = safe_code;
		end
		else if (lnk.in_tick)
		begin
			if (cnt_r == last)
			begin
				cnt_nxt = 2'h0;
				tick_nxt = 1'b1;
				code_nxt = safe_code;
			end
			else
				cnt_nxt = cnt_r + 2'h1;
		end
		half = (code_nxt == `CG_RATIO_DIV4) ? 2'h2 : 2'h1;
		// Level is high in the first half; at /1 it simply stays high
		lvl_nxt = lnk.run & ((code_nxt == `CG_RATIO_DIV1) | (cnt_nxt < half));
	end

	// Stage registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r  <= 2'h0;
			code_r <= `CG_RATIO_DIV4;
			tick_r <= 1'b0;
			lvl_r  <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			code_r <= code_nxt;
			tick_r <= tick_nxt;
			lvl_r  <= lvl_nxt;
		end
	end

	assign lnk.out_tick = tick_r;
	assign lnk.out_clk  = lvl_r;

endmodule

`default_nettype wire

// [src/system_clock_source_and_prescaler.sv]
// Clock source sequencer, prescaler and slow oscillator control.
// Assumes clk is the system clock; option inputs are stable after reset,
// and register writes are single-cycle strobes with data on the same edge.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_params.svh"

module system_clock_source_and_prescaler
	import clock_gen_pkg::*;
#(
	parameter int unsigned OP_STOP_CYCLES = `CG_OP_STOP_CYCLES,
	parameter int unsigned SETTLE_CYC_0   = (1 << `CG_SETTLE_LOG2_0),
	parameter int unsigned SETTLE_CYC_1   = (1 << `CG_SETTLE_LOG2_1),
	parameter int unsigned SETTLE_CYC_2   = (1 << `CG_SETTLE_LOG2_2),
	parameter int unsigned SETTLE_CYC_3   = (1 << `CG_SETTLE_LOG2_3)
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [1:0]  opt_clk_src,
	input  wire logic        opt_slow_osc_locked,
	input  wire logic [1:0]  opt_xtal_settle,
	input  wire logic        stop_req,
	input  wire logic        wake_req,
	input  wire logic        cpu_halt,
	input  wire logic        cpu_div_wr,
	input  wire logic [7:0]  cpu_div_wdata,
	input  wire logic        periph_div_wr,
	input  wire logic [7:0]  periph_div_wdata,
	input  wire logic        slow_mode_wr,
	input  wire logic [7:0]  slow_mode_wdata,
	input  wire logic        settle_sel_wr,
	input  wire logic [7:0]  settle_sel_wdata,
	output logic [7:0]       cpu_divider_select,
	output logic [7:0]       peripheral_divider_select,
	output logic [7:0]       slow_osc_mode_reg,
	output logic [7:0]       wake_settle_select,
	output clk_src_type      sys_clk_src,
	output logic             cpu_released,
	output logic             seq_busy,
	output logic             hs_osc_enable,
	output logic             xtal_osc_enable,
	output logic             osc_in_is_port,
	output logic             osc_out_is_port,
	output logic             osc_in_is_clock,
	output logic             periph_tick,
	output logic             periph_clk,
	output logic             cpu_tick,
	output logic             cpu_clk,
	output logic             slow_osc_enable,
	output logic             watchdog_unit_run,
	output logic             aux_eight_bit_timer_run,
	output logic             watchdog_src_forced_slow
);

	localparam int CNT_W = `CG_CNT_W;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	seq_state_type     state_r, state_nxt;
	logic [CNT_W-1:0]  wait_r, wait_nxt;
	clk_src_type       src_r, src_nxt;
	logic              lock_r, lock_nxt;
	logic              opt_valid_r, opt_valid_nxt;
	logic [7:0]        cpu_div_r, cpu_div_nxt;
	logic [7:0]        per_div_r, per_div_nxt;
	logic [7:0]        slow_mode_r, slow_mode_nxt;
	logic [7:0]        settle_r, settle_nxt;
	logic              released_r, released_nxt;
	logic              busy_r, busy_nxt;
	logic              hs_en_r, hs_en_nxt;
	logic              xtal_en_r, xtal_en_nxt;
	logic              in_port_r, in_port_nxt;
	logic              out_port_r, out_port_nxt;
	logic              in_clk_r, in_clk_nxt;
	logic              slow_en_r, slow_en_nxt;
	logic              wdt_run_r, wdt_run_nxt;
	logic              tmr_run_r, tmr_run_nxt;
	logic              wdt_forced_r, wdt_forced_nxt;
	logic              standby;
	logic              stop_bit;
	logic              locked_now;

	div_link_if per_lnk ();
	div_link_if cpu_lnk ();

	////////////////////////////////////////////////////////////////////////
	// settle code table; the counter loads one less than the length
	function automatic logic [CNT_W-1:0] settle_len(input logic [1:0] code);
		logic [CNT_W-1:0] len;
		len = CNT_W'(SETTLE_CYC_0);
		unique case (code)
			2'h0: len = CNT_W'(SETTLE_CYC_0);
			2'h1: len = CNT_W'(SETTLE_CYC_1);
			2'h2: len = CNT_W'(SETTLE_CYC_2);
			2'h3: len = CNT_W'(SETTLE_CYC_3);
		endcase
		return len - CNT_W'(1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Start-up and stop sequencer
	always_comb
	begin
		state_nxt = state_r;
		wait_nxt = wait_r;
		src_nxt = src_r;
		lock_nxt = lock_r;
		opt_valid_nxt = opt_valid_r;
		unique case (state_r)
			ST_POR_WAIT:
			begin
				if (wait_r == '0)
				begin
					state_nxt = ST_HS_START;
					wait_nxt = CNT_W'(`CG_HS_START_CYCLES - 1);
				end
				else
					wait_nxt = wait_r - CNT_W'(1);
			end
			ST_HS_START:
			begin
				if (wait_r == '0)
					state_nxt = ST_READ_OPT;
				else
					wait_nxt = wait_r - CNT_W'(1);
			end
			ST_READ_OPT:
			begin
				opt_valid_nxt = 1'b1;
				lock_nxt = opt_slow_osc_locked;
				if (opt_clk_src == `CG_OPT_SRC_XTAL)
				begin
					src_nxt = SRC_XTAL;
					state_nxt = ST_XTAL_SETTLE;
					wait_nxt = settle_len(opt_xtal_settle);
				end
				else
				begin
					src_nxt = (opt_clk_src == `CG_OPT_SRC_EXT) ? SRC_EXT : SRC_HS_INT;
					state_nxt = ST_RUN;
				end
			end
			ST_XTAL_SETTLE, ST_WAKE_SETTLE:
			begin
				if (wait_r == '0)
					state_nxt = ST_RUN;
				else
					wait_nxt = wait_r - CNT_W'(1);
			end
			ST_RUN:
			begin
				if (stop_req)
					state_nxt = ST_STOP;
			end
			ST_STOP:
			begin
				if (wake_req && (src_r == SRC_XTAL))
				begin
					state_nxt = ST_WAKE_SETTLE;
					wait_nxt = settle_len(settle_r[`CG_SETTLE_HI:`CG_SETTLE_LO]);
				end
				else if (wake_req)
					state_nxt = ST_RUN;
			end
		endcase
	end

	// Sequencer registers; the option value is caught after release, not at reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r     <= ST_POR_WAIT;
			wait_r      <= CNT_W'(OP_STOP_CYCLES - 1);
			src_r       <= SRC_HS_INT;
			lock_r      <= 1'b0;
			opt_valid_r <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			wait_r      <= wait_nxt;
			src_r       <= src_nxt;
			lock_r      <= lock_nxt;
			opt_valid_r <= opt_valid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers; unused bits always read as zero
	always_comb
	begin
		cpu_div_nxt = cpu_div_r;
		per_div_nxt = per_div_r;
		slow_mode_nxt = slow_mode_r;
		settle_nxt = settle_r;
		if (cpu_div_wr)
			cpu_div_nxt = cpu_div_wdata & `CG_MASK_CPU_DIV;
		if (periph_div_wr)
			per_div_nxt = periph_div_wdata & `CG_MASK_PER_DIV;
		if (slow_mode_wr)
			slow_mode_nxt = slow_mode_wdata & `CG_MASK_SLOW_MODE;
		if (settle_sel_wr)
			settle_nxt = settle_sel_wdata & `CG_MASK_SETTLE;
	end

	// Register file
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cpu_div_r   <= `CG_RST_CPU_DIV;
			per_div_r   <= `CG_RST_PER_DIV;
			slow_mode_r <= `CG_RST_SLOW_MODE;
			settle_r    <= `CG_RST_SETTLE;
		end
		else
		begin
			cpu_div_r   <= cpu_div_nxt;
			per_div_r   <= per_div_nxt;
			slow_mode_r <= slow_mode_nxt;
			settle_r    <= settle_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler: system clock to peripheral clock, then to CPU clock
	// peripheral divide
	assign per_lnk.run     = (state_r == ST_RUN);
	assign per_lnk.in_tick = 1'b1;
	assign per_lnk.code    = per_div_r[`CG_PER_DIV_HI:`CG_PER_DIV_LO];
	assign cpu_lnk.run     = (state_r == ST_RUN);
	assign cpu_lnk.in_tick = per_lnk.out_tick;
	// CPU stage is /1 or /4 of the peripheral clock
	assign cpu_lnk.code    = cpu_div_r[`CG_CPU_DIV_BIT] ? `CG_RATIO_DIV4 : `CG_RATIO_DIV1;

	// Peripheral stage
	clock_divider_stage u_per_stage
	(
		.clk (clk),
		.rst (rst),
		.lnk (per_lnk)
	);

	// CPU stage; one cycle behind the peripheral stage by construction
	clock_divider_stage u_cpu_stage
	(
		.clk (clk),
		.rst (rst),
		.lnk (cpu_lnk)
	);

	assign periph_tick = per_lnk.out_tick;
	assign periph_clk  = per_lnk.out_clk;
	assign cpu_tick    = cpu_lnk.out_tick;
	assign cpu_clk     = cpu_lnk.out_clk;

	////////////////////////////////////////////////////////////////////////
	// Oscillator, pin and slow clock controls
	always_comb
	begin
		standby = (state_r == ST_STOP) | cpu_halt;
		stop_bit = slow_mode_r[`CG_SLOW_STOP_BIT];
		// Before the option value is read the oscillator must not be stoppable
		locked_now = lock_r | ~opt_valid_r;
		released_nxt = (state_nxt == ST_RUN);
		busy_nxt = (state_nxt != ST_RUN) & (state_nxt != ST_STOP);
		hs_en_nxt = (state_nxt == ST_POR_WAIT) | (state_nxt == ST_HS_START) |
			(state_nxt == ST_READ_OPT) | ((src_nxt == SRC_HS_INT) & (state_nxt != ST_STOP));
		xtal_en_nxt = (src_nxt == SRC_XTAL) & opt_valid_nxt & (state_nxt != ST_STOP);
		in_port_nxt = 1'b0;
		out_port_nxt = 1'b0;
		in_clk_nxt = 1'b0;
		if (opt_valid_nxt)
		begin
			unique case (src_nxt)
				SRC_HS_INT:
				begin
					in_port_nxt = 1'b1;
					out_port_nxt = 1'b1;
				end
				SRC_XTAL:
				begin
					in_port_nxt = 1'b0;
					out_port_nxt = 1'b0;
				end
				SRC_EXT:
				begin
					in_clk_nxt = 1'b1;
					out_port_nxt = 1'b1;
				end
			endcase
		end
		slow_en_nxt = locked_now | ~stop_bit;
		wdt_forced_nxt = locked_now;
		wdt_run_nxt = locked_now | (~stop_bit & ~standby);
		tmr_run_nxt = locked_now | ~stop_bit;
	end

	// Status flip-flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			released_r   <= 1'b0;
			busy_r       <= 1'b1;
			hs_en_r      <= 1'b1;
			xtal_en_r    <= 1'b0;
			in_port_r    <= 1'b0;
			out_port_r   <= 1'b0;
			in_clk_r     <= 1'b0;
			slow_en_r    <= 1'b1;
			wdt_run_r    <= 1'b1;
			tmr_run_r    <= 1'b1;
			wdt_forced_r <= 1'b1;
		end
		else
		begin
			released_r   <= released_nxt;
			busy_r       <= busy_nxt;
			hs_en_r      <= hs_en_nxt;
			xtal_en_r    <= xtal_en_nxt;
			in_port_r    <= in_port_nxt;
			out_port_r   <= out_port_nxt;
			in_clk_r     <= in_clk_nxt;
			slow_en_r    <= slow_en_nxt;
			wdt_run_r    <= wdt_run_nxt;
			tmr_run_r    <= tmr_run_nxt;
			wdt_forced_r <= wdt_forced_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output drive
	assign cpu_divider_select        = cpu_div_r;
	assign peripheral_divider_select = per_div_r;
	assign slow_osc_mode_reg         = slow_mode_r;
	assign wake_settle_select        = settle_r;
	assign sys_clk_src               = src_r;
	assign cpu_released              = released_r;
	assign seq_busy                  = busy_r;
	assign hs_osc_enable             = hs_en_r;
	assign xtal_osc_enable           = xtal_en_r;
	assign osc_in_is_port            = in_port_r;
	assign osc_out_is_port           = out_port_r;
	assign osc_in_is_clock           = in_clk_r;
	assign slow_osc_enable           = slow_en_r;
	assign watchdog_unit_run         = wdt_run_r;
	assign aux_eight_bit_timer_run   = tmr_run_r;
	assign watchdog_src_forced_slow  = wdt_forced_r;

endmodule

`default_nettype wire

// [bench/clock_gen_sva.sv]
// Port checker for the clock source sequencer and prescaler.
// Assumes it is bound into the top module, on one clock with synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module clock_gen_sva
	import clock_gen_pkg::*;
#(
	parameter int unsigned OP_STOP_CYCLES = 20
)
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        cpu_halt,
	input wire logic        cpu_div_wr,
	input wire logic [7:0]  cpu_div_wdata,
	input wire logic [7:0]  cpu_divider_select,
	input wire logic [7:0]  peripheral_divider_select,
	input wire logic [7:0]  slow_osc_mode_reg,
	input wire clk_src_type sys_clk_src,
	input wire logic        cpu_released,
	input wire logic        xtal_osc_enable,
	input wire logic        osc_in_is_port,
	input wire logic        osc_out_is_port,
	input wire logic        osc_in_is_clock,
	input wire logic        periph_tick,
	input wire logic        cpu_tick,
	input wire logic        slow_osc_enable,
	input wire logic        watchdog_unit_run,
	input wire logic        aux_eight_bit_timer_run,
	input wire logic        watchdog_src_forced_slow
);
	logic [31:0] since_rst_r;
	logic [31:0] since_rst_nxt;

	// Edges since reset release, used to bound the power-on hold
	always_comb since_rst_nxt = since_rst_r + 32'h1;
	always_ff @(posedge clk) since_rst_r <= rst ? 32'h0 : since_rst_nxt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	a_reg_reset_vals: assert property ($fell(rst) |-> cpu_divider_select == 8'h02 &&
		peripheral_divider_select == 8'h02 && slow_osc_mode_reg == 8'h00 && slow_osc_enable)
		else $error("register reset values wrong");
	a_cpu_div_mask: assert property (cpu_div_wr |=> cpu_divider_select == ($past(cpu_div_wdata) & 8'h02))
		else $error("cpu divider write not masked");
	a_per_quarter_gap: assert property (periph_tick && peripheral_divider_select[1:0] == 2'h2 &&
		$past(peripheral_divider_select[1:0]) == 2'h2 |=> !periph_tick [*3])
		else $error("peripheral quarter period shortened");
	a_cpu_after_per: assert property (cpu_tick |-> $past(periph_tick))
		else $error("cpu tick without peripheral tick");
	a_fast_pin_roles: assert property (cpu_released && sys_clk_src == SRC_HS_INT |->
		osc_in_is_port && osc_out_is_port && !osc_in_is_clock && !xtal_osc_enable)
		else $error("fast source pin roles wrong");
	a_xtal_pin_roles: assert property (cpu_released && sys_clk_src == SRC_XTAL |->
		!osc_in_is_port && !osc_out_is_port && xtal_osc_enable)
		else $error("crystal pin roles wrong");
	a_ext_pin_roles: assert property (cpu_released && sys_clk_src == SRC_EXT |->
		osc_in_is_clock && osc_out_is_port && !osc_in_is_port)
		else $error("external clock pin roles wrong");
	a_stop_bit_gates: assert property (!watchdog_src_forced_slow && !$past(watchdog_src_forced_slow) &&
		slow_osc_mode_reg[0] && $past(slow_osc_mode_reg[0]) |->
		!slow_osc_enable && !watchdog_unit_run && !aux_eight_bit_timer_run)
		else $error("stop bit does not gate slow clock users");
	a_halt_timer_only: assert property (!watchdog_src_forced_slow && !$past(watchdog_src_forced_slow) &&
		!slow_osc_mode_reg[0] && !$past(slow_osc_mode_reg[0]) && cpu_halt && $past(cpu_halt) |->
		!watchdog_unit_run && aux_eight_bit_timer_run && slow_osc_enable)
		else $error("standby gating wrong");
	a_por_hold_time: assert property (cpu_released |-> since_rst_r >= OP_STOP_CYCLES)
		else $error("cpu released before power-on hold");
endmodule

`default_nettype wire

// [bench/tb_system_clock_source_and_prescaler.sv]
// Self-checking bench for the clock source sequencer and prescaler.
// Assumes shortened hold and settle parameters; drives every port directly.
`timescale 1ns/1ps
`default_nettype none

module tb_system_clock_source_and_prescaler
	import clock_gen_pkg::*;
;
	localparam int unsigned OPS = 20;
	localparam int unsigned S0 = 4;
	localparam int unsigned S1 = 8;
	localparam int unsigned S3 = 16;

	logic        clk = 1'b0, rst = 1'b1, stop_req = 1'b0, wake_req = 1'b0, cpu_halt = 1'b0;
	logic [1:0]  opt_clk_src = 2'h0, opt_xtal_settle = 2'h0;
	logic        opt_slow_osc_locked = 1'b0;
	logic        cpu_div_wr = 1'b0, periph_div_wr = 1'b0, slow_mode_wr = 1'b0, settle_sel_wr = 1'b0;
	logic [7:0]  cpu_div_wdata = 8'h00, periph_div_wdata = 8'h00, slow_mode_wdata = 8'h00;
	logic [7:0]  settle_sel_wdata = 8'h00;
	logic [7:0]  cpu_divider_select, peripheral_divider_select, slow_osc_mode_reg, wake_settle_select;
	clk_src_type sys_clk_src;
	logic        cpu_released, seq_busy, hs_osc_enable, xtal_osc_enable, osc_in_is_port, osc_out_is_port;
	logic        osc_in_is_clock, periph_tick, periph_clk, cpu_tick, cpu_clk, slow_osc_enable;
	logic        watchdog_unit_run, aux_eight_bit_timer_run, watchdog_src_forced_slow;
	int          miscompares = 0, cmp_count = 0, t0, t1, t2, n0, n3, np, nc;
	int          pv [6] = '{0, 1, 0, 2, 1, 2};
	int          cv [6] = '{0, 0, 2, 0, 2, 2};
	int          cx [6] = '{1, 2, 4, 4, 8, 16};

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	system_clock_source_and_prescaler #(.OP_STOP_CYCLES(OPS), .SETTLE_CYC_0(S0), .SETTLE_CYC_1(S1),
		.SETTLE_CYC_2(12), .SETTLE_CYC_3(S3)) dut_u (.clk, .rst, .opt_clk_src, .opt_slow_osc_locked,
		.opt_xtal_settle, .stop_req, .wake_req, .cpu_halt, .cpu_div_wr, .cpu_div_wdata, .periph_div_wr,
		.periph_div_wdata, .slow_mode_wr, .slow_mode_wdata, .settle_sel_wr, .settle_sel_wdata,
		.cpu_divider_select, .peripheral_divider_select, .slow_osc_mode_reg, .wake_settle_select,
		.sys_clk_src, .cpu_released, .seq_busy, .hs_osc_enable, .xtal_osc_enable, .osc_in_is_port,
		.osc_out_is_port, .osc_in_is_clock, .periph_tick, .periph_clk, .cpu_tick, .cpu_clk,
		.slow_osc_enable, .watchdog_unit_run, .aux_eight_bit_timer_run, .watchdog_src_forced_slow);

	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// A wait that ran out ends the run as a failure
	task automatic guard(input int n);
		if (n >= 300)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	// Reset with the given options, then count cycles until the CPU runs
	task automatic boot(input logic [1:0] src, input logic lk, input logic [1:0] xs, output int n);
		@(posedge clk);
		{rst, opt_clk_src, opt_slow_osc_locked, opt_xtal_settle} <= {1'b1, src, lk, xs};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check({seq_busy, cpu_released}, 2'h2);
		n = 1;
		while (cpu_released !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		guard(n);
	endtask

	// One-cycle write strobe to register k
	task automatic wr(input int k, input logic [7:0] d);
		@(posedge clk);
		case (k)
			0: {cpu_div_wr, cpu_div_wdata} <= {1'b1, d};
			1: {periph_div_wr, periph_div_wdata} <= {1'b1, d};
			2: {slow_mode_wr, slow_mode_wdata} <= {1'b1, d};
			default: {settle_sel_wr, settle_sel_wdata} <= {1'b1, d};
		endcase
		@(posedge clk);
		{cpu_div_wr, periph_div_wr, slow_mode_wr, settle_sel_wr} <= 4'h0;
	endtask

	// Cycles between two ticks of the peripheral (s=0) or CPU (s=1) clock
	task automatic period(input logic s, output int n);
		int i;
		i = 0;
		@(negedge clk);
		while ((s ? cpu_tick : periph_tick) !== 1'b1 && i < 300)
		begin
			@(negedge clk);
			i++;
		end
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while ((s ? cpu_tick : periph_tick) !== 1'b1 && n < 300);
		guard(i);
		guard(n);
	endtask

	// Enter stop, look at the stopped outputs, then wake and time the restart
	task automatic stop_wake(output int n);
		@(posedge clk) stop_req <= 1'b1;
		@(posedge clk) stop_req <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({cpu_released, seq_busy, hs_osc_enable, xtal_osc_enable, cpu_tick, cpu_clk, periph_clk,
			slow_osc_enable, watchdog_unit_run, aux_eight_bit_timer_run}, 10'h005);
		@(posedge clk) wake_req <= 1'b1;
		@(posedge clk) wake_req <= 1'b0;
		n = 0;
		while (cpu_released !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		guard(n);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		// Fast internal start: reset values, hold time, free pins
		boot(2'h0, 1'b0, 2'h3, t0);
		check({cpu_divider_select, peripheral_divider_select, slow_osc_mode_reg}, 24'h020200);
		check(t0 >= OPS + 15 && t0 <= OPS + 20, 1);
		check({sys_clk_src, osc_in_is_port, osc_out_is_port, osc_in_is_clock}, 5'h06);
		@(negedge clk);
		check({slow_osc_enable, watchdog_src_forced_slow, seq_busy, hs_osc_enable}, 4'h9);
		$display("test fast start done");
		// Writes keep only the defined bits
		wr(0, 8'hff);
		wr(1, 8'hfe);
		wr(2, 8'hff);
		wr(3, 8'hff);
		@(negedge clk);
		check({cpu_divider_select, peripheral_divider_select, slow_osc_mode_reg, wake_settle_select},
			32'h02020103);
		$display("test register masks done");
		// Every legal divider pair
		for (int i = 0; i < 6; i++)
		begin
			wr(1, pv[i][7:0]);
			wr(0, cv[i][7:0]);
			repeat (40) @(posedge clk);
			period(1'b0, np);
			check(periph_clk, 1'b1);
			period(1'b1, nc);
			check(cpu_clk, 1'b1);
			check(np, 1 << pv[i]);
			check(nc, cx[i]);
		end
		$display("test divider ratios done");
		// Stop bit and standby gating, stop bit writable
		wr(2, 8'h01);
		repeat (3) @(posedge clk);
		check({slow_osc_enable, watchdog_unit_run, aux_eight_bit_timer_run}, 3'h0);
		wr(2, 8'h00);
		cpu_halt <= 1'b1;
		repeat (3) @(posedge clk);
		check({slow_osc_enable, watchdog_unit_run, aux_eight_bit_timer_run}, 3'h5);
		cpu_halt <= 1'b0;
		repeat (3) @(posedge clk);
		check({slow_osc_enable, watchdog_unit_run, aux_eight_bit_timer_run}, 3'h7);
		$display("test slow oscillator done");
		// Crystal start waits the configured settle, wake waits the software one
		boot(2'h1, 1'b0, 2'h1, t1);
		check(t1 - t0, S1);
		check({sys_clk_src, osc_in_is_port, osc_out_is_port, xtal_osc_enable}, 5'h09);
		wr(3, 8'h03);
		stop_wake(n3);
		wr(3, 8'h00);
		stop_wake(n0);
		check(n3 - n0, S3 - S0);
		$display("test crystal start done");
		// External clock with locked slow oscillator ignores the stop bit
		boot(2'h2, 1'b1, 2'h3, t2);
		check(t2, t0);
		check({sys_clk_src, osc_in_is_clock, osc_out_is_port, osc_in_is_port}, 5'h16);
		wr(2, 8'h01);
		cpu_halt <= 1'b1;
		repeat (3) @(posedge clk);
		check({slow_osc_enable, watchdog_unit_run, aux_eight_bit_timer_run, watchdog_src_forced_slow},
			4'hf);
		cpu_halt <= 1'b0;
		$display("test external locked done");
		tally_and_finish();
	end
endmodule

bind system_clock_source_and_prescaler clock_gen_sva #(.OP_STOP_CYCLES(OP_STOP_CYCLES)) chk_u (.clk, .rst,
	.cpu_halt, .cpu_div_wr, .cpu_div_wdata, .cpu_divider_select, .peripheral_divider_select,
	.slow_osc_mode_reg, .sys_clk_src, .cpu_released, .xtal_osc_enable, .osc_in_is_port, .osc_out_is_port,
	.osc_in_is_clock, .periph_tick, .cpu_tick, .slow_osc_enable, .watchdog_unit_run,
	.aux_eight_bit_timer_run, .watchdog_src_forced_slow);

`default_nettype wire
